//--- verilog/acsq_regs.svh
// Timing counts, limits and field constants of the conversion sequencer.
// Assumes a 25 MHz core clock; the minimum divide and sequence counts derive from printed times.
`ifndef ACSQ_REGS_SVH
`define ACSQ_REGS_SVH

// Core clock period, in its own units
`define ACSQ_CLK_PERIOD_NS   40
`define ACSQ_CLK_PERIOD_PS   40000

// Shortest converter clock period, in picoseconds
`define ACSQ_TCAD_MIN_PS     33300
// Least integer divide that keeps the converter clock slow enough
`define ACSQ_MIN_DIV \
  ((`ACSQ_TCAD_MIN_PS + `ACSQ_CLK_PERIOD_PS - 1) / `ACSQ_CLK_PERIOD_PS)

// Shortest full sequence, in nanoseconds, and its cycle count
`define ACSQ_TSEQ_MIN_NS     500
`define ACSQ_SEQ_MIN_CYC \
  ((`ACSQ_TSEQ_MIN_NS + `ACSQ_CLK_PERIOD_NS - 1) / `ACSQ_CLK_PERIOD_NS)

// Fixed delays, in core clock periods
`define ACSQ_START_DLY_CYC   2
`define ACSQ_EOC_DLY_CYC     2
`define ACSQ_IRQ_DLY_CYC     2

// Converter clock counts
`define ACSQ_SH_MIN_TICKS    2
`define ACSQ_SH_MAX_TICKS    32
`define ACSQ_CONV_TICKS      10

// Result code range and buffer depth
`define ACSQ_RES_W           10
`define ACSQ_CODE_ZERO       10'h000
`define ACSQ_CODE_MAX        10'h3FF
`define ACSQ_FIFO_DEPTH      4

`endif

//--- verilog/acsq_pkg.sv
// Types shared by the conversion sequencer and its result buffer.
// Assumes acsq_regs.svh is on the include path.
`include "acsq_regs.svh"

package acsq_pkg;

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ACSQ_IDLE  = 6'b000001,
    ACSQ_DLY   = 6'b000010,
    ACSQ_SAMP  = 6'b000100,
    ACSQ_CONV  = 6'b001000,
    ACSQ_EOCW  = 6'b010000,
    ACSQ_STORE = 6'b100000
  } acsq_state_t;

  // What the analogue core reports at the end of a conversion
  typedef struct packed {
    logic                   below_lo;
    logic                   above_hi;
    logic [`ACSQ_RES_W-1:0] code;
  } acsq_core_t;

  // Controls for the analogue core
  typedef struct packed {
    logic tick;
    logic sample;
    logic convert;
    logic eoc;
  } acsq_ctl_t;

endpackage

//--- verilog/acsq_fifo.sv
// Small synchronous FIFO carrying conversion results to the consumer.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "acsq_regs.svh"

module acsq_fifo
  import acsq_pkg::*;
#(
  parameter int W     = `ACSQ_RES_W,
  parameter int DEPTH = `ACSQ_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [AW:0]             count;
    logic                    vld;
    logic [W-1:0]            head;
  } acsq_fifo_t;

  acsq_fifo_t s_ff;
  acsq_fifo_t nxt_s;
  logic       do_wr;
  logic       do_rd;

  // Flags come from the count, so full and empty are never guessed
  assign in_ready  = (s_ff.count != (AW+1)'(DEPTH));
  // Head and valid are registered copies, so the drain side sees flops
  assign out_valid = s_ff.vld;
  assign out_data  = s_ff.head;
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  // Next state: write, read and occupancy
  always_comb begin
    nxt_s = s_ff;
    if (do_wr) begin
      nxt_s.mem[s_ff.wr_ptr] = in_data;
      nxt_s.wr_ptr = (s_ff.wr_ptr == AW'(DEPTH-1)) ? '0 : s_ff.wr_ptr + 1'b1;
    end
    if (do_rd) begin
      nxt_s.rd_ptr = (s_ff.rd_ptr == AW'(DEPTH-1)) ? '0 : s_ff.rd_ptr + 1'b1;
    end
    case ({do_wr, do_rd})
      2'b10:   nxt_s.count = s_ff.count + 1'b1;
      2'b01:   nxt_s.count = s_ff.count - 1'b1;
      default: nxt_s.count = s_ff.count;
    endcase
    // Look ahead one cycle: show the head that the next state will hold
    nxt_s.vld  = (nxt_s.count != '0);
    nxt_s.head = nxt_s.mem[nxt_s.rd_ptr];
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule // acsq_fifo

//--- verilog/acsq_sequencer.sv
// Conversion sequencer: start delay, sample window, conversion phase,
// result load, completion flag and delayed interrupt.
// Assumes a 25 MHz core clock, synchronous inputs and an analogue core
// that steps on the converter clock tick and presents its code at eoc.
//
// Overview of operation
// - After a start request the sample window opens no sooner than two core clock periods later.
// - The sample window lasts 2 to 32 converter clock periods as chosen by the acquisition window select.
// - The conversion phase runs at least ten converter clock periods before end of conversion is flagged.
// - The result is loaded no sooner than two core clock periods after end of conversion.
// - The interrupt rises two core clock periods after the completion flag is set.
// - The converter clock period is never shorter than 33.3 ns, the divider being clamped to enforce it.
// - Start delay, sample window, conversion and load delay together take at least 500 ns.
// - Results are 10-bit codes 000h to 3FFh, saturating at zero below the low reference and at full scale above the high one.
`timescale 1ns/1ps
`include "acsq_regs.svh"

module acsq_sequencer
  import acsq_pkg::*;
(
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // Control settings
  input  wire logic                   start_req,
  input  wire logic [4:0]             acquisition_window_select,
  input  wire logic [3:0]             conv_clk_div,
  input  wire logic                   done_clr,
  // Analogue core
  input  wire acsq_core_t             core_in,
  output acsq_ctl_t                   core_ctl,
  // Status
  output logic                        busy,
  output logic                        conversion_done,
  output logic                        conversion_done_interrupt,
  output logic [`ACSQ_RES_W-1:0]      result,
  // Result stream
  output logic                        res_valid,
  input  wire logic                   res_ready,
  output logic [`ACSQ_RES_W-1:0]      res_data
);

  // Whole sequencer state; one register keeps every output a flop
  typedef struct packed {
    acsq_state_t            st;
    logic [9:0]             cnt;
    logic [1:0]             wcnt;
    logic [3:0]             div_cnt;
    logic [5:0]             ticks;
    logic                   tick;
    logic                   sample;
    logic                   convert;
    logic                   eoc;
    logic [`ACSQ_RES_W-1:0] code;
    logic [`ACSQ_RES_W-1:0] result;
    logic                   push;
    logic                   done;
    logic                   irq_dly;
    logic                   irq;
    logic                   busy;
  } acsq_seq_t;

  acsq_seq_t              s_ff;
  acsq_seq_t              nxt_s;
  logic [3:0]             div_eff;
  logic [5:0]             sh_len;
  logic                   adc_edge;
  logic                   fifo_in_ready;
  logic [`ACSQ_RES_W-1:0] sat_code;

  // Divider clamped so the converter clock never runs too fast
  // At this core clock any divide meets the minimum period; the clamp
  // mainly keeps a zero setting from wrapping round to a divide of sixteen
  assign div_eff = (conv_clk_div < 4'(`ACSQ_MIN_DIV)) ?
                   4'(`ACSQ_MIN_DIV) : conv_clk_div;

  // Window length is select plus one, floored at the shortest window
  // Trade-off: selects 0 and 1 both give the two-tick window
  assign sh_len = (acquisition_window_select <
                   5'(`ACSQ_SH_MIN_TICKS - 1)) ?
                  6'(`ACSQ_SH_MIN_TICKS) :
                  6'(acquisition_window_select) + 6'd1;

  // Converter clock edge: integer division of the core clock
  // The tick is an enable pulse, never a second clock, so nothing crosses
  assign adc_edge = (s_ff.st == ACSQ_SAMP || s_ff.st == ACSQ_CONV) &&
                    (s_ff.div_cnt == div_eff - 4'd1);

  // Out-of-range inputs pin to the ends of the code range
  assign sat_code = core_in.below_lo ? `ACSQ_CODE_ZERO :
                    core_in.above_hi ? `ACSQ_CODE_MAX :
                    core_in.code;

  // Next-state logic of the whole sequencer
  always_comb begin
    nxt_s         = s_ff;
    nxt_s.tick    = 1'b0;
    nxt_s.eoc     = 1'b0;
    nxt_s.push    = 1'b0;
    // Flag set wins over a clear in the same cycle
    nxt_s.done    = (s_ff.st == ACSQ_STORE && fifo_in_ready) |
                    (s_ff.done & ~done_clr);
    // Two stages from flag to interrupt
    nxt_s.irq_dly = s_ff.done;
    nxt_s.irq     = s_ff.irq_dly;
    // Divider runs only while the core is clocked
    if (adc_edge) begin
      nxt_s.div_cnt = 4'd0;
      nxt_s.tick    = 1'b1;
    end else if (s_ff.st == ACSQ_SAMP || s_ff.st == ACSQ_CONV) begin
      nxt_s.div_cnt = s_ff.div_cnt + 4'd1;
    end
    // Elapsed cycles since the request, saturating
    if (s_ff.st != ACSQ_IDLE && s_ff.cnt != 10'h3FF) begin
      nxt_s.cnt = s_ff.cnt + 10'd1;
    end
    case (s_ff.st)
      ACSQ_IDLE: begin
        // A request while busy is simply ignored; nothing records it
        if (start_req) begin
          nxt_s.st   = ACSQ_DLY;
          nxt_s.cnt  = 10'd0;
          nxt_s.busy = 1'b1;
        end
      end
      ACSQ_DLY: begin
        // Window opens only after the full start delay
        if (s_ff.cnt == 10'(`ACSQ_START_DLY_CYC - 1)) begin
          nxt_s.st      = ACSQ_SAMP;
          nxt_s.sample  = 1'b1;
          nxt_s.div_cnt = 4'd0;
          nxt_s.ticks   = 6'd0;
        end
      end
      ACSQ_SAMP: begin
        // The window shuts on the tick that reaches the chosen length
        if (adc_edge) begin
          nxt_s.ticks = s_ff.ticks + 6'd1;
          if (s_ff.ticks + 6'd1 == sh_len) begin
            nxt_s.st      = ACSQ_CONV;
            nxt_s.sample  = 1'b0;
            nxt_s.convert = 1'b1;
            nxt_s.ticks   = 6'd0;
          end
        end
      end
      ACSQ_CONV: begin
        if (adc_edge && s_ff.ticks != 6'(`ACSQ_CONV_TICKS)) begin
          nxt_s.ticks = s_ff.ticks + 6'd1;
        end
        // Stretch the phase if the whole sequence would end too soon
        // At this clock it never bites, but it keeps a faster clock safe
        if (s_ff.ticks == 6'(`ACSQ_CONV_TICKS) &&
            s_ff.cnt >= 10'(`ACSQ_SEQ_MIN_CYC - `ACSQ_EOC_DLY_CYC)) begin
          nxt_s.st      = ACSQ_EOCW;
          nxt_s.convert = 1'b0;
          nxt_s.eoc     = 1'b1;
          nxt_s.code    = sat_code;
          nxt_s.wcnt    = 2'd0;
        end
      end
      ACSQ_EOCW: begin
        // Hold off the load so the captured code has settled
        nxt_s.wcnt = s_ff.wcnt + 2'd1;
        if (s_ff.wcnt == 2'(`ACSQ_EOC_DLY_CYC - 1)) begin
          nxt_s.st = ACSQ_STORE;
        end
      end
      ACSQ_STORE: begin
        // A full buffer holds the sequencer here and blocks new starts
        if (fifo_in_ready) begin
          nxt_s.result = s_ff.code;
          nxt_s.push   = 1'b1;
          nxt_s.st     = ACSQ_IDLE;
          nxt_s.busy   = 1'b0;
        end
      end
      default: begin
        nxt_s.st = ACSQ_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      // Idle is a one-hot code, not the all-zero word
      s_ff    <= '0;
      s_ff.st <= ACSQ_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register
  assign core_ctl.tick             = s_ff.tick;
  assign core_ctl.sample           = s_ff.sample;
  assign core_ctl.convert          = s_ff.convert;
  assign core_ctl.eoc              = s_ff.eoc;
  assign busy                      = s_ff.busy;
  assign conversion_done           = s_ff.done;
  assign conversion_done_interrupt = s_ff.irq;
  assign result                    = s_ff.result;

  // Result buffer; room was seen the cycle before the push, and only
  // the drain side changes it meanwhile, so the push is never dropped
  acsq_fifo #(
    .W     (`ACSQ_RES_W),
    .DEPTH (`ACSQ_FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (s_ff.push),
    .in_ready  (fifo_in_ready),
    .in_data   (s_ff.result),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

endmodule // acsq_sequencer

//--- tb/acsq_sequencer_asserts.sv
// Checker for the conversion sequencer, bound to its top-level ports.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "acsq_regs.svh"

module acsq_seq_chk
  import acsq_pkg::*;
(
  // Clock and reset
  input wire logic                   core_clk,
  input wire logic                   rst_n,
  // Controls
  input wire logic                   start_req,
  input wire logic [3:0]             conv_clk_div,
  // Core side
  input wire acsq_ctl_t              core_ctl,
  // Status and stream
  input wire logic                   busy,
  input wire logic                   conversion_done,
  input wire logic                   conversion_done_interrupt,
  input wire logic [`ACSQ_RES_W-1:0] result,
  input wire logic                   res_valid,
  input wire logic                   res_ready,
  input wire logic [`ACSQ_RES_W-1:0] res_data
);
  logic [9:0] cv_ff;
  logic [9:0] bz_ff;
  // Cycles spent converting, and cycles spent busy; a new window restarts cv
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cv_ff <= 10'h000;
      bz_ff <= 10'h000;
    end else begin
      cv_ff <= core_ctl.sample ? 10'h000 : cv_ff + 10'(core_ctl.convert);
      bz_ff <= busy ? bz_ff + 10'h001 : 10'h000;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_take; start_req && !busy |=> busy; endproperty
  a_take: assert property (p_take) else $error("start not taken");
  property p_dly;
    $rose(busy) |-> !core_ctl.sample ##1 !core_ctl.sample ##1 core_ctl.sample;
  endproperty
  a_dly: assert property (p_dly) else $error("window opens early");
  property p_win; $rose(core_ctl.sample) |-> core_ctl.sample [*2]; endproperty
  a_win: assert property (p_win) else $error("window too short");
  // Ten converter ticks, each as many core cycles as the clamped divide
  property p_conv;
    core_ctl.eoc |-> cv_ff >= 10'(`ACSQ_CONV_TICKS) *
      ((conv_clk_div == 4'h0) ? 10'h001 : 10'(conv_clk_div));
  endproperty
  a_conv: assert property (p_conv) else $error("conversion short");
  property p_load; core_ctl.eoc |=> $stable(result) [*2]; endproperty
  a_load: assert property (p_load) else $error("result loads early");
  property p_irq;
    conversion_done_interrupt == $past(conversion_done, 2);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt delay");
  property p_seq; $fell(busy) |-> bz_ff >= `ACSQ_SEQ_MIN_CYC; endproperty
  a_seq: assert property (p_seq) else $error("sequence too short");
  property p_tick; core_ctl.tick && conv_clk_div > 4'h1 |=> !core_ctl.tick;
  endproperty
  a_tick: assert property (p_tick) else $error("tick too fast");
  property p_hold; res_valid && !res_ready |=> res_valid && $stable(res_data);
  endproperty
  a_hold: assert property (p_hold) else $error("stream head moved");
  c_eoc: cover property (core_ctl.eoc);
  c_irq: cover property ($rose(conversion_done_interrupt));
  c_full: cover property (busy && res_valid && !res_ready);
endmodule // acsq_seq_chk

bind acsq_sequencer acsq_seq_chk u_chk (.*);

//--- tb/acsq_core_model.sv
// Behavioural analogue core: tracks the level while the window is open,
// then holds it. Assumes the bench keeps vin steady per conversion.
`timescale 1ns/1ps

module acsq_core_model
  import acsq_pkg::*;
(
  // Clock
  input wire logic               core_clk,
  // Analogue level in code steps
  input wire logic signed [15:0] vin,
  // Sequencer side
  input wire acsq_ctl_t          core_ctl,
  output acsq_core_t             core_in
);
  logic signed [15:0] held_ff;
  acsq_core_t         cv;
  // Track while sampling; the last value is held once the window shuts
  always_ff @(posedge core_clk)
    if (core_ctl.sample) held_ff <= vin;
  // Junk outside conversion so a late read of the code shows up
  always_comb begin
    cv.below_lo = held_ff < 16'sh0000;
    cv.above_hi = held_ff > 16'sh03FF;
    cv.code     = held_ff[9:0];
    core_in     = (core_ctl.convert || core_ctl.eoc) ? cv : ~cv;
  end
endmodule // acsq_core_model

//--- tb/acsq_sequencer_tb.sv
// Self-checking bench for the conversion sequencer with a behavioural core
// and a queue of expected results. Needs the checker and core model files.
`timescale 1ns/1ps
`include "acsq_regs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t got %0d want %0d", $time, a, b); end end

module acsq_sequencer_tb
  import acsq_pkg::*;
  ();
  logic                   core_clk = 0, rst_n = 0, start_req = 0;
  logic                   done_clr = 0, res_ready = 0, drain = 0;
  logic [4:0]             sel = 5'h00;
  logic [3:0]             div = 4'h0;
  logic signed [15:0]     vin = 16'sh0000;
  acsq_core_t             core_in;
  acsq_ctl_t              core_ctl;
  logic                   busy, done, irq, res_valid;
  logic [`ACSQ_RES_W-1:0] result, res_data, e, r_exp;
  logic [`ACSQ_RES_W-1:0] exp_q[$];
  int                     n_mismatch = 0, n_tests = 0, sw = 0, win_exp = 0;
  int                     seed = 32'h5096E265;

  always #20 core_clk = ~core_clk;

  acsq_sequencer dut (.core_clk(core_clk), .rst_n(rst_n),
    .start_req(start_req), .acquisition_window_select(sel),
    .conv_clk_div(div), .done_clr(done_clr), .core_in(core_in),
    .core_ctl(core_ctl), .busy(busy), .conversion_done(done),
    .conversion_done_interrupt(irq), .result(result),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
  acsq_core_model core (.core_clk(core_clk), .vin(vin),
    .core_ctl(core_ctl), .core_in(core_in));

  function automatic logic [9:0] sat(input int v);
    sat = v < 0 ? 10'h000 : v > 1023 ? 10'h3FF : v[9:0];
  endfunction

  // Random consumer stalls; each delivered result and window length checked
  always @(posedge core_clk) begin
    res_ready <= drain & 1'($random(seed));
    if (rst_n && res_valid === 1'b1 && res_ready === 1'b1) begin
      e = exp_q.pop_front();
      `CHK(res_data, e)
    end
    if (core_ctl.sample === 1'b1) sw++;
    else if (sw > 0) begin
      `CHK(sw, win_exp)
      sw = 0;
    end
  end

  task automatic go(input int v, input int lim);
    int k;
    @(posedge core_clk);
    vin <= v[15:0];
    start_req <= 1'b1;
    win_exp = (sel < 1 ? 2 : sel + 1) * (div < 1 ? 1 : div);
    exp_q.push_back(sat(v));
    r_exp = sat(v);
    @(posedge core_clk);
    start_req <= 1'b0;
    // Busy only shows the request one edge after it was taken
    @(posedge core_clk);
    for (k = 0; k < lim && busy !== 1'b0; k++) @(posedge core_clk);
  endtask

  task automatic end_sim;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog far beyond the expected run of well under two thousand cycles
  initial begin
    repeat (30000) @(posedge core_clk);
    n_mismatch++;
    end_sim;
  end

  initial begin
    int i;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    drain <= 1'b1;
    go(-5, 400);
    go(1500, 400);
    // Window selects 0, 1 and 31 against divides 0, 1 and 3, flag then clear
    for (i = 0; i < 9; i++) begin
      sel <= (i % 3 == 0) ? 5'h00 : (i % 3 == 1) ? 5'h01 : 5'h1F;
      div <= (i < 3) ? 4'h0 : (i < 6) ? 4'h1 : 4'h3;
      go($random(seed) % 800 + 400, 400);
      `CHK(result, r_exp)
      `CHK(done, 1'b1)
      repeat (2) @(posedge core_clk);
      `CHK(irq, 1'b1)
      done_clr <= 1'b1;
      @(posedge core_clk);
      done_clr <= 1'b0;
      repeat (3) @(posedge core_clk);
      `CHK(irq, 1'b0)
      `CHK(done, 1'b0)
    end
    // Fill the buffer with no consumer; the fifth result must wait in store
    for (i = 0; i < 100 && exp_q.size() > 0; i++) @(posedge core_clk);
    drain <= 1'b0;
    for (i = 0; i < 5; i++) go($random(seed) % 800 + 400, 200);
    `CHK(busy, 1'b1)
    drain <= 1'b1;
    for (i = 0; i < 600 && exp_q.size() > 0; i++) @(posedge core_clk);
    `CHK(exp_q.size(), 0)
    end_sim;
  end
endmodule // acsq_sequencer_tb
